// ---- logic/iep_pkg.sv ----
package iep_pkg;

  // Register byte addresses on the register bus.
  localparam logic [7:0] ADDR_ENABLE_FOUR = 8'h00;
  localparam logic [7:0] ADDR_PRIORITY = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Enable bit positions in the fourth enable register.
  localparam int BIT_LOW_VOLTAGE = 8;
  localparam int BIT_CRC_GEN = 3;
  localparam int BIT_SERIAL_TWO_ERR = 2;
  localparam int BIT_SERIAL_ONE_ERR = 1;
  localparam logic [15:0] ENABLE_FOUR_MASK = 16'h010e;
  localparam logic [15:0] ENABLE_FOUR_RESET = 16'h0000;

  // Priority field positions; each field is three bits wide.
  localparam int PRI_W = 3;
  localparam int POS_TIMER_ONE = 12;
  localparam int POS_COMPARE_ONE = 8;
  localparam int POS_CAPTURE_ONE = 4;
  localparam int POS_EXT_ZERO = 0;
  localparam logic [15:0] PRIORITY_MASK = 16'h7777;
  localparam logic [15:0] PRIORITY_RESET = 16'h4444;

  // Number of requesting sources handled by this block.
  localparam int NSRC = 4;
  localparam logic [3:0] SRC_RESET = 4'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- logic/iep_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
// Registered per-source gate: forwards a flag only while its enable is set.
module iep_gate (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flag,
  input wire logic enable,
  input wire logic [2:0] priority_in,
  output logic req_r,
  output logic [2:0] level_r
);

  // Request and its priority tag are registered together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= 1'b0;
      level_r <= 3'h0;
    end else begin
      req_r <= flag & enable;
      level_r <= priority_in;
    end
  end

endmodule
`default_nettype wire

// ---- logic/iep_top.sv ----
// Summary of operation
// - Low-voltage request enable sits at bit 8; one passes, zero blocks.
// - CRC generator request enable sits at bit 3; one enables, zero disables.
// - Second serial port error enable sits at bit 2.
// - First serial port error enable sits at bit 1.
// - Bits 15-9, 7-4 and 0 of enable register read zero, ignore writes.
// - Implemented enable bits are read/write and clear to zero at reset.
// - Timer-one priority at 14-12, compare-one at 10-8, reset 100, 15/11 zero.
// - Low byte holds fields at 6-4 and 2-0, reset 100, bits 7/3 zero.
// - Field 6-4 is capture channel one, field 2-0 is external interrupt zero.
`timescale 1ns/100ps
`default_nettype none
module iep_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_voltage_flag,
  input wire logic crc_gen_flag,
  input wire logic serial_two_err_flag,
  input wire logic serial_one_err_flag,
  input wire logic timer_one_flag,
  input wire logic compare_one_flag,
  input wire logic capture_one_flag,
  input wire logic ext_irq_zero_flag,
  output logic [3:0] core_req_r,
  output logic [11:0] core_level_r,
  output logic [2:0] timer_one_priority_r,
  output logic [2:0] compare_one_priority_r,
  output logic [2:0] capture_one_priority_r,
  output logic [2:0] ext_irq_zero_priority_r,
  output logic irq_r
);

  // Merges a 32-bit write into a 16-bit register under byte strobes and a keep mask.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] keep);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v & keep;
  endfunction

  // Tells whether an address names a mapped register.
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == iep_pkg::ADDR_ENABLE_FOUR) || (a == iep_pkg::ADDR_PRIORITY) ||
           (a == iep_pkg::ADDR_FLAGS) || (a == iep_pkg::ADDR_IRQ_STATUS) ||
           (a == iep_pkg::ADDR_IRQ_MASK);
  endfunction

  // Tells whether a transfer that fires this cycle targets the given register.
  function automatic logic reg_hit(input logic fire, input logic [7:0] a, input logic [7:0] r);
    return fire && (a == r);
  endfunction

  // Maps a priority field index to its bit position, index 0 being the lowest field.
  function automatic int field_pos(input int idx);
    unique case (idx)
      0: return iep_pkg::POS_EXT_ZERO;
      1: return iep_pkg::POS_CAPTURE_ONE;
      2: return iep_pkg::POS_COMPARE_ONE;
      default: return iep_pkg::POS_TIMER_ONE;
    endcase
  endfunction

  // Software-visible register state and flag history.
  logic [15:0] enable_four_r;
  logic [15:0] priority_r;
  logic [3:0] irq_status_r;
  logic [3:0] irq_mask_r;
  logic [3:0] flag_prev_r;

  // Write address and data held until both halves have arrived.
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r;
  logic w_have_r;

  // Per-source vectors, bit order serial one, serial two, CRC, low voltage.
  logic [3:0] src_flag;
  logic [3:0] src_en;
  logic [3:0] src_rise;
  logic [11:0] src_pri;
  logic [3:0] gate_req;
  logic [11:0] gate_level;
  logic [7:0] all_flags;

  // Bus transfer strobes and register selects.
  logic wr_fire;
  logic rd_fire;
  logic status_read;
  logic wr_enable_four;
  logic wr_priority;
  logic wr_mask;
  logic [15:0] rd_val;

  // Enabled sources in enable-register order: serial one, serial two, CRC, low voltage.
  assign src_flag = {low_voltage_flag,
                     crc_gen_flag,
                     serial_two_err_flag,
                     serial_one_err_flag};
  assign src_en = {enable_four_r[iep_pkg::BIT_LOW_VOLTAGE],
                   enable_four_r[iep_pkg::BIT_CRC_GEN],
                   enable_four_r[iep_pkg::BIT_SERIAL_TWO_ERR],
                   enable_four_r[iep_pkg::BIT_SERIAL_ONE_ERR]};
  assign src_rise = src_flag & ~flag_prev_r;

  // Every flag pin as software sees it live; the upper four have no enable here.
  assign all_flags = {ext_irq_zero_flag,
                      capture_one_flag,
                      compare_one_flag,
                      timer_one_flag,
                      src_flag};

  // Priority of these sources lives in other registers; they reuse the capture field here.
  assign src_pri = {4{priority_r[iep_pkg::POS_CAPTURE_ONE +: iep_pkg::PRI_W]}};

  // One gate per source forwards the flag while enabled.
  genvar gi;
  generate
    for (gi = 0; gi < iep_pkg::NSRC; gi++) begin : g_src
      iep_gate iep_gate_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .flag(src_flag[gi]),
        .enable(src_en[gi]),
        .priority_in(src_pri[gi*3 +: 3]),
        .req_r(gate_req[gi]),
        .level_r(gate_level[gi*3 +: 3])
      );
    end
  endgenerate

  assign core_req_r = gate_req;
  assign core_level_r = gate_level;

  // Write fires once both address and data are held.
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign status_read = reg_hit(rd_fire, s_axi_araddr, iep_pkg::ADDR_IRQ_STATUS);

  // Register selects for the write that fires this cycle.
  assign wr_enable_four = reg_hit(wr_fire, aw_addr_r, iep_pkg::ADDR_ENABLE_FOUR);
  assign wr_priority = reg_hit(wr_fire, aw_addr_r, iep_pkg::ADDR_PRIORITY);
  assign wr_mask = reg_hit(wr_fire, aw_addr_r, iep_pkg::ADDR_IRQ_MASK);

  // Write address ready: a one-cycle pulse once a new address is offered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
    end
  end

  // Write address channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  // Write data ready: a one-cycle pulse once new data is offered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
    end
  end

  // Write data channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= iep_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(aw_addr_r) ? iep_pkg::RESP_OKAY : iep_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Fourth enable register: unimplemented bits are masked away on every write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_four_r <= iep_pkg::ENABLE_FOUR_RESET;
    end else if (wr_enable_four) begin
      enable_four_r <= merge16(enable_four_r, w_data_r, w_strb_r,
                               iep_pkg::ENABLE_FOUR_MASK);
    end
  end

  // Priority register: four 3-bit fields, gaps held at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priority_r <= iep_pkg::PRIORITY_RESET;
    end else if (wr_priority) begin
      priority_r <= merge16(priority_r, w_data_r, w_strb_r,
                            iep_pkg::PRIORITY_MASK);
    end
  end

  // Priority fields driven out to the core's arbitration, one registered copy per field.
  genvar fi;
  generate
    for (fi = 0; fi < iep_pkg::NSRC; fi++) begin : g_pri
      logic [2:0] field_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          field_r <= iep_pkg::PRIORITY_RESET[field_pos(fi) +: iep_pkg::PRI_W];
        end else begin
          field_r <= priority_r[field_pos(fi) +: iep_pkg::PRI_W];
        end
      end
    end
  endgenerate

  // Field copies named for their sources.
  assign timer_one_priority_r = g_pri[3].field_r;
  assign compare_one_priority_r = g_pri[2].field_r;
  assign capture_one_priority_r = g_pri[1].field_r;
  assign ext_irq_zero_priority_r = g_pri[0].field_r;

  // Flag history for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_prev_r <= iep_pkg::SRC_RESET;
    end else begin
      flag_prev_r <= src_flag;
    end
  end

  // Sticky status of enabled requests; a new event wins over the clearing read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= iep_pkg::SRC_RESET;
    end else begin
      irq_status_r <= (status_read ? 4'h0 : irq_status_r) | (src_rise & src_en);
    end
  end

  // Interrupt mask register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= iep_pkg::SRC_RESET;
    end else if (wr_mask && w_strb_r[0]) begin
      irq_mask_r <= w_data_r[3:0];
    end
  end

  // Level interrupt output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // Read data selection.
  always_comb begin
    rd_val = 16'h0000;
    unique case (s_axi_araddr)
      iep_pkg::ADDR_ENABLE_FOUR: rd_val = enable_four_r;
      iep_pkg::ADDR_PRIORITY: rd_val = priority_r;
      iep_pkg::ADDR_FLAGS: rd_val = {8'h00, all_flags};
      iep_pkg::ADDR_IRQ_STATUS: rd_val = {12'h000, irq_status_r};
      iep_pkg::ADDR_IRQ_MASK: rd_val = {12'h000, irq_mask_r};
      default: rd_val = 16'h0000;
    endcase
  end

  // Read address ready: a one-cycle pulse while no answer is pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  // Read channel: one read outstanding, answer one cycle after acceptance.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= iep_pkg::RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_val};
        s_axi_rresp <= addr_ok(s_axi_araddr) ? iep_pkg::RESP_OKAY : iep_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/iep_top_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// Watches the top ports for gating, tagging and bus timing relations.
module iep_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_voltage_flag,
  input wire logic crc_gen_flag,
  input wire logic serial_two_err_flag,
  input wire logic serial_one_err_flag,
  input wire logic [3:0] core_req_r,
  input wire logic [11:0] core_level_r,
  input wire logic [2:0] timer_one_priority_r,
  input wire logic [2:0] compare_one_priority_r,
  input wire logic [2:0] capture_one_priority_r,
  input wire logic [2:0] ext_irq_zero_priority_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A request may only show when its flag was high one cycle before.
  a_req_gate: assert property ((core_req_r & ~$past({low_voltage_flag,
    crc_gen_flag, serial_two_err_flag, serial_one_err_flag})) == 4'h0) else $error("stray request");
  a_pri_reset: assert property ($rose(aresetn) |-> {timer_one_priority_r,
    compare_one_priority_r, capture_one_priority_r, ext_irq_zero_priority_r} == 12'h924)
    else $error("priority reset value");
  a_level_tag: assert property ($past(aresetn, 2) && $past(aresetn) &&
    $stable(capture_one_priority_r) && $past($stable(capture_one_priority_r))
    |-> core_level_r == {4{capture_one_priority_r}}) else $error("request tag");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_pad: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule
`default_nettype wire

// ---- tb/iep_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Core side: latches the gated requests and the first tag each cycle.
module iep_core_model (
  input wire logic aclk,
  input wire logic [3:0] core_req_r,
  input wire logic [11:0] core_level_r,
  output logic [3:0] held_r,
  output logic [2:0] tag_r
);
  // Acceptance stage of the core.
  always_ff @(posedge aclk) begin
    held_r <= core_req_r;
    tag_r <= core_level_r[2:0];
  end
endmodule
`default_nettype wire

// ---- tb/tb_interrupt_enable_priority_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_enable_priority_regs;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic low_voltage_flag, crc_gen_flag, serial_two_err_flag, serial_one_err_flag, irq_r;
  logic timer_one_flag, compare_one_flag, capture_one_flag, ext_irq_zero_flag;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fl;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, core_req_r, held_r, x;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] core_level_r;
  logic [2:0] timer_one_priority_r, compare_one_priority_r, capture_one_priority_r;
  logic [2:0] ext_irq_zero_priority_r, tag_r;
  logic [15:0] en, pr;
  logic [33:0] exq[$];
  logic [33:0] e;
  int n_fail, checked;
  iep_top iep_top_i (.*);
  iep_core_model iep_core_model_i (.*);
  // Spreads the flag vector onto the eight flag inputs.
  always_comb {ext_irq_zero_flag, capture_one_flag, compare_one_flag, timer_one_flag,
    low_voltage_flag, crc_gen_flag, serial_two_err_flag, serial_one_err_flag} = fl;
  // Free-running clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic fail(input string m);
    n_fail++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] v, input string m);
    checked++;
    if (g !== v) fail(m);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) begin
      fail("write hang");
      complete_run();
    end
    chk({14'h0, s_axi_bresp}, {14'h0, er}, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] ex);
    int n;
    n = 0;
    @(posedge aclk);
    exq.push_back(ex);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) begin
      fail("read hang");
      complete_run();
    end
  endtask
  // Compares each read beat with the oldest expected note.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exq.size() > 0) begin
      e = exq.pop_front();
      checked++;
      if ({s_axi_rresp, s_axi_rdata} !== e) fail("read data");
    end
  end
  // Main sequence of tests.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, fl, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    checked = 0;
    void'($urandom(61162));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(iep_pkg::ADDR_ENABLE_FOUR, 34'h0);
    rd(iep_pkg::ADDR_PRIORITY, 34'h4444);
    chk({4'h0, timer_one_priority_r, compare_one_priority_r, capture_one_priority_r,
      ext_irq_zero_priority_r}, 16'h0924, "priority reset");
    $display("test reset done");
    wr(iep_pkg::ADDR_ENABLE_FOUR, 32'h0102, iep_pkg::RESP_OKAY);
    wr(iep_pkg::ADDR_IRQ_MASK, 32'h0, iep_pkg::RESP_OKAY);
    fl <= 8'h08;
    repeat (3) @(posedge aclk);
    chk({12'h0, core_req_r}, 16'h0008, "low voltage pass");
    chk({15'h0, irq_r}, 16'h0, "masked irq");
    wr(iep_pkg::ADDR_IRQ_MASK, 32'h8, iep_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({15'h0, irq_r}, 16'h1, "unmasked irq");
    rd(iep_pkg::ADDR_IRQ_STATUS, 34'h8);
    repeat (3) @(posedge aclk);
    chk({15'h0, irq_r}, 16'h0, "irq after clear");
    $display("test irq done");
    for (int i = 0; i < 8; i++) begin
      en = 16'($urandom());
      fl <= 8'($urandom());
      wr(iep_pkg::ADDR_ENABLE_FOUR, {16'hffff, en}, iep_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      x = {fl[3] & en[8], fl[2] & en[3], fl[1] & en[2], fl[0] & en[1]};
      chk({12'h0, core_req_r}, {12'h0, x}, "gated requests");
      chk({12'h0, held_r}, {12'h0, x}, "core accepts");
      rd(iep_pkg::ADDR_FLAGS, {26'h0, fl});
      rd(iep_pkg::ADDR_ENABLE_FOUR, {18'h0, en & 16'h010e});
    end
    $display("test gate done");
    for (int i = 0; i < 3; i++) begin
      pr = 16'($urandom());
      wr(iep_pkg::ADDR_PRIORITY, {16'hffff, pr}, iep_pkg::RESP_OKAY);
      rd(iep_pkg::ADDR_PRIORITY, {18'h0, pr & 16'h7777});
      chk({4'h0, timer_one_priority_r, compare_one_priority_r, capture_one_priority_r,
        ext_irq_zero_priority_r}, {4'h0, pr[14:12], pr[10:8], pr[6:4], pr[2:0]}, "fields");
      chk({4'h0, core_level_r}, {4'h0, {4{pr[6:4]}}}, "tags");
      chk({13'h0, tag_r}, {13'h0, pr[6:4]}, "core tag");
    end
    wr(8'h20, 32'hffff, iep_pkg::RESP_SLVERR);
    rd(8'h20, {iep_pkg::RESP_SLVERR, 32'h0});
    repeat (3) @(posedge aclk);
    $display("test priority done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(iep_pkg::ADDR_ENABLE_FOUR, 34'h0);
    rd(iep_pkg::ADDR_PRIORITY, 34'h4444);
    chk({15'h0, irq_r}, 16'h0, "irq after reset");
    $display("test reset again done");
    complete_run();
  end
endmodule
bind iep_top iep_top_asserts iep_top_asserts_i (.*);
`default_nettype wire
